// *** src/pfd_timer_core.sv ***
// Waveform timer core with fault input modes, dithering and counter capture
//
// How it works
// - Mode 1: own input ends own on-time, counter waits, resumes at opposite dead-time.
// - Mode 2: end on-time, run opposite dead/on-time, wait, resume current dead-time.
// - Mode 3: while input active keep repeating the opposite compare cycle.
// - Mode 4: any input forces both outputs off; counter runs on.
// - Mode 5: any input stops outputs; only alternating dead-times run while active.
// - Mode 6: any input ends on-times and holds counter; resumes at opposite dead-time.
// - Mode 7: any input halts outputs and counter until software restart.
// - Mode 8: own rising input in on-time jumps to opposite dead-time.
// - Mode 9: own rising input blanks own output for rest of on-time.
// - Mode 10: own input blanks own output, and for the rest of that on-time.
// - Dither accumulator adds step at each end of on-time B; overflow adds one clock to each selected state.
// - Placement selects on-time B, on-times A+B, dead-time B or dead-times A+B.
// - Period growth per overflow depends on ramp mode and placement.
// - Dual-slope mode disables dithering.
// - Stretch that adds no period shortens the following state.
// - One-ramp dead-time B dither: dead-time B +1, on-time B -1.
// - Two capture blocks snapshot the counter on event or software strobe.
// - Event capture happens only with the input's action bit set.
// - Event capture sets its trigger flag; enabled flag raises the request.
// - Mode 7 restart while input still active halts again at once.
//
// Chosen here: the plain strobed port and the register offsets.

`timescale 1ns/1ps

module pfd_timer_core
	import pfd_pkg::*;
#(
	parameter int CNT_W = 12
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [4:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	input wire logic ev_a,
	input wire logic ev_b,
	output logic waveform_out_a,
	output logic waveform_out_b,
	output logic trig_irq
);
	logic en_q, en_d;
	logic [1:0] waveform_gen_mode_q, waveform_gen_mode_d;
	logic [3:0] fault_input_mode_sel_q, fault_input_mode_sel_d;
	logic [1:0] event_ctrl_reg_q, event_ctrl_reg_d;
	logic [1:0] dither_place_sel_q, dither_place_sel_d;
	logic [7:0] dstep_q, dstep_d, acc_q, acc_d;
	logic dith_q, dith_d;
	logic [7:0] len_q [4];
	logic [7:0] len_d [4];
	logic [1:0] irq_enable_reg_q, irq_enable_reg_d;
	logic [1:0] irq_flags_reg_q, irq_flags_reg_d;
	logic [CNT_W-1:0] count_snapshot_a_q, count_snapshot_a_d;
	logic [CNT_W-1:0] count_snapshot_b_q, count_snapshot_b_d;
	logic [7:0] hi_shadow_q, hi_shadow_d, rd_data_q, rd_data_d;
	pfd_state_type st_q, st_d, nxt, prv, opp_dt, cur_dt;
	logic [CNT_W-1:0] cnt_q, cnt_d, eff;
	logic wait_q, wait_d, wsrc_q, wsrc_d, wany_q, wany_d, arm_q, arm_d;
	logic halt_q, halt_d, blank_a_q, blank_a_d, blank_b_q, blank_b_d;
	logic ev_a_q, ev_b_q, wo_a_q, wo_a_d, wo_b_q, wo_b_d, irq_q, irq_d;
	logic in_a, own, own_r, any, sig, last, is_ot, ext, cmp, kill;
	logic restart, scap_a, scap_b, cap_a, cap_b;
	logic [8:0] sum;
	logic [3:0] mode;

	function automatic logic covers(input logic [1:0] sel, input pfd_state_type s);
		case (sel)
			DSEL_OTB: covers = s == ST_OTB;
			DSEL_OTAB: covers = s == ST_OTA || s == ST_OTB;
			DSEL_DTB: covers = s == ST_DTB;
			default: covers = s == ST_DTA || s == ST_DTB;
		endcase
	endfunction : covers

	// Whether a stretch of state s lengthens the whole period in mode wg
	function automatic logic adds(input logic [1:0] wg, input pfd_state_type s);
		case (wg)
			WG_FOUR: adds = 1'b1;
			WG_TWO: adds = s == ST_OTA || s == ST_OTB;
			WG_ONE: adds = s == ST_OTB;
			default: adds = 1'b0;
		endcase
	endfunction : adds

	always_comb begin
		en_d = en_q;
		waveform_gen_mode_d = waveform_gen_mode_q;
		fault_input_mode_sel_d = fault_input_mode_sel_q;
		event_ctrl_reg_d = event_ctrl_reg_q;
		dither_place_sel_d = dither_place_sel_q;
		dstep_d = dstep_q;
		acc_d = acc_q;
		dith_d = dith_q;
		for (int i = 0; i < 4; i++) begin
			len_d[i] = len_q[i];
		end
		irq_enable_reg_d = irq_enable_reg_q;
		irq_flags_reg_d = irq_flags_reg_q;
		count_snapshot_a_d = count_snapshot_a_q;
		count_snapshot_b_d = count_snapshot_b_q;
		hi_shadow_d = hi_shadow_q;
		rd_data_d = 8'h00;
		st_d = st_q;
		cnt_d = cnt_q;
		wait_d = wait_q;
		wsrc_d = wsrc_q;
		wany_d = wany_q;
		arm_d = arm_q;
		halt_d = halt_q;
		sum = 9'h000;
		mode = fault_input_mode_sel_q;
		restart = wr_en && addr == PFD_A_CMD && wdata[CMD_RESTART];
		scap_a = wr_en && addr == PFD_A_CMD && wdata[CMD_SCAP_A];
		scap_b = wr_en && addr == PFD_A_CMD && wdata[CMD_SCAP_B];

		if (wr_en) begin
			case (addr)
				PFD_A_CTRL: begin
					en_d = wdata[CTRL_EN];
					waveform_gen_mode_d = wdata[CTRL_WG+:2];
				end
				PFD_A_MODE: fault_input_mode_sel_d = wdata[3:0];
				PFD_A_EVENT_CTRL_REG: event_ctrl_reg_d = wdata[1:0];
				PFD_A_DITHER_CTRL_REG: dither_place_sel_d = wdata[1:0];
				PFD_A_DITSTEP: dstep_d = wdata;
				PFD_A_IRQEN: irq_enable_reg_d = wdata[1:0];
				PFD_A_IRQFL: irq_flags_reg_d = irq_flags_reg_q & ~wdata[1:0];
				default: begin
					if (addr[4:2] == PFD_A_LEN[4:2]) begin
						len_d[addr[1:0]] = wdata;
					end
				end
			endcase
		end

		if (rd_en) begin
			case (addr)
				PFD_A_CTRL: rd_data_d = {5'h00, waveform_gen_mode_q, en_q};
				PFD_A_MODE: rd_data_d = {4'h0, fault_input_mode_sel_q};
				PFD_A_EVENT_CTRL_REG: rd_data_d = {6'h00, event_ctrl_reg_q};
				PFD_A_DITHER_CTRL_REG: rd_data_d = {6'h00, dither_place_sel_q};
				PFD_A_DITSTEP: rd_data_d = dstep_q;
				PFD_A_IRQEN: rd_data_d = {6'h00, irq_enable_reg_q};
				PFD_A_IRQFL: rd_data_d = {6'h00, irq_flags_reg_q};
				PFD_A_CAPA_L: begin
					rd_data_d = count_snapshot_a_q[7:0];
					hi_shadow_d = 8'(count_snapshot_a_q >> 8);
				end
				PFD_A_CAPB_L: begin
					rd_data_d = count_snapshot_b_q[7:0];
					hi_shadow_d = 8'(count_snapshot_b_q >> 8);
				end
				PFD_A_CAPA_H, PFD_A_CAPB_H: rd_data_d = hi_shadow_q;
				PFD_A_STATUS: rd_data_d = {4'h0, halt_q, wait_q, 2'(st_q)};
				default: begin
					if (addr[4:2] == PFD_A_LEN[4:2]) begin
						rd_data_d = len_q[addr[1:0]];
					end
				end
			endcase
		end

		// Sequencer
		in_a = st_q == ST_DTA || st_q == ST_OTA;
		is_ot = st_q == ST_OTA || st_q == ST_OTB;
		own = in_a ? ev_a : ev_b;
		own_r = in_a ? (ev_a && !ev_a_q) : (ev_b && !ev_b_q);
		any = ev_a || ev_b;
		sig = wany_q ? any : (wsrc_q ? ev_a : ev_b);
		nxt = pfd_state_type'(2'(st_q + 2'h1));
		prv = pfd_state_type'(2'(st_q - 2'h1));
		opp_dt = in_a ? ST_DTB : ST_DTA;
		cur_dt = in_a ? ST_DTA : ST_DTB;
		ext = dith_q && covers(dither_place_sel_q, st_q);
		cmp = dith_q && covers(dither_place_sel_q, prv) && !adds(waveform_gen_mode_q, prv);
		eff = CNT_W'(len_q[st_q]) + CNT_W'(ext) - CNT_W'(cmp);
		last = CNT_W'(cnt_q + 1'b1) >= eff;

		if (!en_q) begin
			st_d = ST_DTA;
			cnt_d = '0;
			wait_d = 1'b0;
			arm_d = 1'b0;
			halt_d = 1'b0;
		end else begin
			if (halt_q) begin
				if (restart) begin
					halt_d = 1'b0;
					st_d = cur_dt;
					cnt_d = '0;
				end
			end else if (wait_q) begin
				if (!sig) begin
					wait_d = 1'b0;
				end
			end else if (!last) begin
				cnt_d = CNT_W'(cnt_q + 1'b1);
			end else begin
				cnt_d = '0;
				st_d = nxt;
				if (st_q == ST_OTB) begin
					sum = {1'b0, acc_q} + {1'b0, dstep_q};
					acc_d = sum[7:0];
					dith_d = sum[8] && waveform_gen_mode_q != WG_DUAL;
				end
				if (arm_q && is_ot) begin
					if (sig && mode == FIM_EXEC_WAIT) begin
						wait_d = 1'b1;
						st_d = st_q;
						cnt_d = cnt_q;
					end else if (sig && mode == FIM_EXEC_RUN) begin
						st_d = prv;
					end else begin
						arm_d = 1'b0;
					end
				end
				if (mode == FIM_DT_ONLY && any && !is_ot) begin
					st_d = pfd_state_type'(2'(st_q + 2'h2));
				end
			end
			// A restart that meets a live input halts again
			if (mode == FIM_SW_WAIT && any) begin
				halt_d = 1'b1;
			end else if (!halt_q) begin
				case (mode)
					FIM_JUMP_WAIT, FIM_EXEC_WAIT, FIM_EXEC_RUN: begin
						if (own && !arm_q && !wait_q) begin
							st_d = opp_dt;
							cnt_d = '0;
							wsrc_d = in_a;
							wany_d = 1'b0;
							wait_d = mode == FIM_JUMP_WAIT;
							arm_d = mode != FIM_JUMP_WAIT;
						end
					end
					FIM_DT_ONLY: begin
						if (any && is_ot) begin
							st_d = nxt;
							cnt_d = '0;
						end
					end
					FIM_STOP_WAIT: begin
						if (any && !wait_q) begin
							st_d = opp_dt;
							cnt_d = '0;
							wany_d = 1'b1;
							wait_d = 1'b1;
						end
					end
					FIM_EDGE_JUMP: begin
						if (own_r && is_ot) begin
							st_d = nxt;
							cnt_d = '0;
						end
					end
					default: ;
				endcase
			end
		end
		if (waveform_gen_mode_q == WG_DUAL) begin
			dith_d = 1'b0;
		end

		// Blanking holds to the end of the on-time it started in
		blank_a_d = en_q && ((blank_a_q && st_q == ST_OTA && st_d == ST_OTA)
			|| (mode == FIM_EDGE_BLANK && st_q == ST_OTA && ev_a && !ev_a_q)
			|| (mode == FIM_LEVEL_BLANK && ev_a));
		blank_b_d = en_q && ((blank_b_q && st_q == ST_OTB && st_d == ST_OTB)
			|| (mode == FIM_EDGE_BLANK && st_q == ST_OTB && ev_b && !ev_b_q)
			|| (mode == FIM_LEVEL_BLANK && ev_b));
		kill = halt_d || wait_d
			|| (mode >= FIM_OUT_OFF && mode <= FIM_SW_WAIT && any);
		wo_a_d = en_q && st_d == ST_OTA && !blank_a_d && !kill;
		wo_b_d = en_q && st_d == ST_OTB && !blank_b_d && !kill;

		// Capture; a new event beats a clear in the same cycle
		cap_a = ev_a && !ev_a_q && event_ctrl_reg_q[0];
		cap_b = ev_b && !ev_b_q && event_ctrl_reg_q[1];
		if (cap_a || scap_a) begin
			count_snapshot_a_d = cnt_q;
		end
		if (cap_b || scap_b) begin
			count_snapshot_b_d = cnt_q;
		end
		if (cap_a) begin
			irq_flags_reg_d[0] = 1'b1;
		end
		if (cap_b) begin
			irq_flags_reg_d[1] = 1'b1;
		end
		irq_d = |(irq_flags_reg_d & irq_enable_reg_d);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_q <= 1'b0;
			waveform_gen_mode_q <= WG_ONE;
			fault_input_mode_sel_q <= 4'h0;
			event_ctrl_reg_q <= 2'h0;
			dither_place_sel_q <= DSEL_OTB;
			dstep_q <= DITSTEP_RST;
			acc_q <= 8'h00;
			dith_q <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				len_q[i] <= LEN_RST;
			end
			irq_enable_reg_q <= 2'h0;
			irq_flags_reg_q <= 2'h0;
			count_snapshot_a_q <= '0;
			count_snapshot_b_q <= '0;
			hi_shadow_q <= 8'h00;
			rd_data_q <= 8'h00;
			st_q <= ST_DTA;
			cnt_q <= '0;
			wait_q <= 1'b0;
			wsrc_q <= 1'b0;
			wany_q <= 1'b0;
			arm_q <= 1'b0;
			halt_q <= 1'b0;
			blank_a_q <= 1'b0;
			blank_b_q <= 1'b0;
			ev_a_q <= 1'b0;
			ev_b_q <= 1'b0;
			wo_a_q <= 1'b0;
			wo_b_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			en_q <= en_d;
			waveform_gen_mode_q <= waveform_gen_mode_d;
			fault_input_mode_sel_q <= fault_input_mode_sel_d;
			event_ctrl_reg_q <= event_ctrl_reg_d;
			dither_place_sel_q <= dither_place_sel_d;
			dstep_q <= dstep_d;
			acc_q <= acc_d;
			dith_q <= dith_d;
			for (int i = 0; i < 4; i++) begin
				len_q[i] <= len_d[i];
			end
			irq_enable_reg_q <= irq_enable_reg_d;
			irq_flags_reg_q <= irq_flags_reg_d;
			count_snapshot_a_q <= count_snapshot_a_d;
			count_snapshot_b_q <= count_snapshot_b_d;
			hi_shadow_q <= hi_shadow_d;
			rd_data_q <= rd_data_d;
			st_q <= st_d;
			cnt_q <= cnt_d;
			wait_q <= wait_d;
			wsrc_q <= wsrc_d;
			wany_q <= wany_d;
			arm_q <= arm_d;
			halt_q <= halt_d;
			blank_a_q <= blank_a_d;
			blank_b_q <= blank_b_d;
			ev_a_q <= ev_a;
			ev_b_q <= ev_b;
			wo_a_q <= wo_a_d;
			wo_b_q <= wo_b_d;
			irq_q <= irq_d;
		end
	end

	assign rd_data = rd_data_q;
	assign waveform_out_a = wo_a_q;
	assign waveform_out_b = wo_b_q;
	assign trig_irq = irq_q;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	halt_outputs_off_a: assert property (halt_q |-> !wo_a_q && !wo_b_q)
		else $error("outputs active while halted");
	restart_halts_again_a: assert property (en_q && mode == FIM_SW_WAIT && ev_b
		|=> halt_q [*1] ##0 !wo_b_q)
		else $error("live input did not halt counter");
	mode4_off_a: assert property (mode == FIM_OUT_OFF && (ev_a || ev_b)
		|=> !wo_a_q && !wo_b_q)
		else $error("outputs on during mode 4 fault");
	mode1_jump_a: assert property (en_q && mode == FIM_JUMP_WAIT && !halt_q && !wait_q
		&& !arm_q && ev_a && (st_q == ST_DTA || st_q == ST_OTA) |=> st_q == ST_DTB && wait_q)
		else $error("mode 1 did not jump and wait");
	wait_hold_a: assert property (en_q && wait_q && sig |=> $stable(cnt_q))
		else $error("counter moved while waiting");
	capture_a_a: assert property (ev_a && !ev_a_q && event_ctrl_reg_q[0]
		|=> irq_flags_reg_q[0] && count_snapshot_a_q == $past(cnt_q))
		else $error("event capture A lost");
	no_action_a: assert property (!event_ctrl_reg_q[1] && !(wr_en && addr == PFD_A_CMD)
		|=> $stable(count_snapshot_b_q))
		else $error("capture B without action bit");
	dual_dither_a: assert property (waveform_gen_mode_q == WG_DUAL |=> !dith_q)
		else $error("dither active in dual slope");
	level_blank_a: assert property (mode == FIM_LEVEL_BLANK && ev_a |=> !wo_a_q)
		else $error("output A on during mode 10 input");
	edge_blank_a: assert property (en_q && mode == FIM_EDGE_BLANK && st_q == ST_OTB
		&& ev_b && !ev_b_q ##1 st_q == ST_OTB |-> !wo_b_q)
		else $error("output B not blanked after edge");
endmodule : pfd_timer_core

// *** shared/pfd_pkg.sv ***
// Constants and types shared by the fault, dither and capture timer block
package pfd_pkg;
	// Register byte addresses
	localparam logic [4:0] PFD_A_CTRL = 5'h00;
	localparam logic [4:0] PFD_A_MODE = 5'h01;
	localparam logic [4:0] PFD_A_EVENT_CTRL_REG = 5'h02;
	localparam logic [4:0] PFD_A_DITHER_CTRL_REG = 5'h03;
	localparam logic [4:0] PFD_A_DITSTEP = 5'h04;
	localparam logic [4:0] PFD_A_CMD = 5'h05;
	localparam logic [4:0] PFD_A_IRQEN = 5'h06;
	localparam logic [4:0] PFD_A_IRQFL = 5'h07;
	localparam logic [4:0] PFD_A_LEN = 5'h08;
	localparam logic [4:0] PFD_A_CAPA_L = 5'h0C;
	localparam logic [4:0] PFD_A_CAPA_H = 5'h0D;
	localparam logic [4:0] PFD_A_CAPB_L = 5'h0E;
	localparam logic [4:0] PFD_A_CAPB_H = 5'h0F;
	localparam logic [4:0] PFD_A_STATUS = 5'h10;
	// Field positions
	localparam int CTRL_EN = 0;
	localparam int CTRL_WG = 1;
	localparam int CMD_RESTART = 0;
	localparam int CMD_SCAP_A = 1;
	localparam int CMD_SCAP_B = 2;
	// Values after reset
	localparam logic [7:0] LEN_RST = 8'h04;
	localparam logic [7:0] DITSTEP_RST = 8'h00;
	// Waveform generation modes
	localparam logic [1:0] WG_ONE = 2'h0;
	localparam logic [1:0] WG_TWO = 2'h1;
	localparam logic [1:0] WG_FOUR = 2'h2;
	localparam logic [1:0] WG_DUAL = 2'h3;
	// Fault input modes
	localparam logic [3:0] FIM_JUMP_WAIT = 4'h1;
	localparam logic [3:0] FIM_EXEC_WAIT = 4'h2;
	localparam logic [3:0] FIM_EXEC_RUN = 4'h3;
	localparam logic [3:0] FIM_OUT_OFF = 4'h4;
	localparam logic [3:0] FIM_DT_ONLY = 4'h5;
	localparam logic [3:0] FIM_STOP_WAIT = 4'h6;
	localparam logic [3:0] FIM_SW_WAIT = 4'h7;
	localparam logic [3:0] FIM_EDGE_JUMP = 4'h8;
	localparam logic [3:0] FIM_EDGE_BLANK = 4'h9;
	localparam logic [3:0] FIM_LEVEL_BLANK = 4'hA;
	// Dither placement choices
	localparam logic [1:0] DSEL_OTB = 2'h0;
	localparam logic [1:0] DSEL_OTAB = 2'h1;
	localparam logic [1:0] DSEL_DTB = 2'h2;
	localparam logic [1:0] DSEL_DTAB = 2'h3;
	typedef enum logic [1:0] {ST_DTA, ST_OTA, ST_DTB, ST_OTB} pfd_state_type;
endpackage : pfd_pkg

// *** verif/pfd_event_net.sv ***
// Model of the event routing network that feeds the timer event inputs
`timescale 1ns/1ps
module pfd_event_net (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic src_a,
	input wire logic src_b,
	output logic ev_a,
	output logic ev_b
);
	// One routing stage: an event reaches the timer one clock after its source
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ev_a <= 1'b0;
			ev_b <= 1'b0;
		end else begin
			ev_a <= src_a;
			ev_b <= src_b;
		end
	end
endmodule : pfd_event_net

// *** verif/test_pfd_timer_core.sv ***
// Self-checking bench for the fault, dither and capture timer block
`timescale 1ns/1ps
module test_pfd_timer_core;
	import pfd_pkg::*;
	logic ref_clk, rst_n, wr_en, rd_en, src_a, src_b, ev_a, ev_b;
	logic waveform_out_a, waveform_out_b, trig_irq;
	logic [4:0] addr;
	logic [7:0] wdata, rd_data, d;
	int n_fail, compares;

	pfd_timer_core #(.CNT_W(12)) pfd_timer_core_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.ev_a(ev_a), .ev_b(ev_b), .waveform_out_a(waveform_out_a),
		.waveform_out_b(waveform_out_b), .trig_irq(trig_irq));
	pfd_event_net pfd_event_net_inst (.ref_clk(ref_clk), .rst_n(rst_n), .src_a(src_a),
		.src_b(src_b), .ev_a(ev_a), .ev_b(ev_b));

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask : wr

	// Data stand only in the cycle after the strobe, so sample just after that edge
	task automatic rd(input logic [4:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1 v = rd_data;
	endtask : rd

	// Cycles until output A next rises, bounded so a dead output cannot hang us
	task automatic rise(output int t);
		t = 0;
		while (waveform_out_a !== 1'b0 && t < 200) begin
			@(posedge ref_clk);
			#1 t++;
		end
		while (waveform_out_a !== 1'b1 && t < 200) begin
			@(posedge ref_clk);
			#1 t++;
		end
	endtask : rise

	task automatic per_chk(input string nm, input int n, input int exp);
		int t, s;
		s = 0;
		rise(t);
		repeat (n) begin
			rise(t);
			s += t;
		end
		chk(nm, exp[15:0], s[15:0]);
	endtask : per_chk

	task automatic reset_vals();
		for (int i = 0; i < 4; i++) begin
			rd(PFD_A_LEN + 5'(i), d);
			chk("len", {8'h00, LEN_RST}, {8'h00, d});
		end
		rd(PFD_A_DITSTEP, d);
		chk("step", {8'h00, DITSTEP_RST}, {8'h00, d});
		rd(PFD_A_MODE, d);
		chk("mode", 16'h0000, {8'h00, d});
		rd(PFD_A_CMD, d);
		chk("cmd", 16'h0000, {8'h00, d});
		rd(5'h1F, d);
		chk("unmapped", 16'h0000, {8'h00, d});
	endtask : reset_vals

	task automatic no_effect();
		logic [3:0] m [2] = '{4'h0, 4'hB};
		wr(PFD_A_CTRL, 8'h01);
		foreach (m[i]) begin
			wr(PFD_A_MODE, {4'h0, m[i]});
			src_a <= 1'b1;
			per_chk("period", 2, 32);
			src_a <= 1'b0;
		end
	endtask : no_effect

	task automatic mode1();
		int t;
		wr(PFD_A_MODE, {4'h0, FIM_JUMP_WAIT});
		rise(t);
		src_a <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rd(PFD_A_STATUS, d);
		chk("wait", 16'h0001, {15'h0, d[2]});
		chk("out_a", 16'h0000, {15'h0, waveform_out_a});
		src_a <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rd(PFD_A_STATUS, d);
		chk("resume", 16'h0002, {13'h0, d[2:0]});
	endtask : mode1

	task automatic mode4();
		int t;
		logic bad;
		bad = 1'b0;
		wr(PFD_A_MODE, {4'h0, FIM_OUT_OFF});
		rise(t);
		src_b <= 1'b1;
		repeat (2) @(posedge ref_clk);
		repeat (20) begin
			@(posedge ref_clk);
			#1 bad |= waveform_out_a | waveform_out_b;
		end
		chk("both_off", 16'h0000, {15'h0, bad});
		src_b <= 1'b0;
		per_chk("period", 1, 16);
	endtask : mode4

	task automatic mode7();
		wr(PFD_A_MODE, {4'h0, FIM_SW_WAIT});
		src_b <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rd(PFD_A_STATUS, d);
		chk("halt", 16'h0001, {15'h0, d[3]});
		wr(PFD_A_CMD, 8'h01);
		repeat (3) @(posedge ref_clk);
		rd(PFD_A_STATUS, d);
		chk("rehalt", 16'h0001, {15'h0, d[3]});
		chk("outs", 16'h0000, {14'h0, waveform_out_a, waveform_out_b});
		src_b <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rd(PFD_A_STATUS, d);
		chk("still", 16'h0001, {15'h0, d[3]});
		wr(PFD_A_CMD, 8'h01);
		repeat (2) @(posedge ref_clk);
		rd(PFD_A_STATUS, d);
		chk("run", 16'h0000, {15'h0, d[3]});
		wr(PFD_A_MODE, 8'h00);
	endtask : mode7

	// Disable then enable, so the counter is at a known place: returns at the enabling edge
	task automatic sync();
		wr(PFD_A_CTRL, 8'h00);
		wr(PFD_A_CTRL, 8'h01);
	endtask : sync

	// Input A lands in on-time A; the status is sampled as it stands 16 cycles after enable
	task automatic fault_a(input logic [3:0] m, input logic [7:0] exp);
		wr(PFD_A_MODE, {4'h0, m});
		sync();
		repeat (4) @(posedge ref_clk);
		src_a <= 1'b1;
		repeat (11) @(posedge ref_clk);
		rd(PFD_A_STATUS, d);
		chk("flow", {8'h00, exp}, {8'h00, d});
		chk("outs", 16'h0000, {14'h0, waveform_out_a, waveform_out_b});
		src_a <= 1'b0;
	endtask : fault_a

	// Input B rises in on-time B; A rises too, to show it leaves output B alone
	task automatic edge_b(input logic [3:0] m, input logic [7:0] exp);
		wr(PFD_A_MODE, {4'h0, m});
		sync();
		repeat (12) @(posedge ref_clk);
		src_a <= 1'b1;
		src_b <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1 chk("out_b", 16'h0000, {15'h0, waveform_out_b});
		repeat (2) @(posedge ref_clk);
		rd(PFD_A_STATUS, d);
		chk("flow", {8'h00, exp}, {8'h00, d});
		src_a <= 1'b0;
		src_b <= 1'b0;
	endtask : edge_b

	// Counter after the enabling edge runs 0,1,2,3 per state; event seen two edges later
	task automatic capture();
		wr(PFD_A_MODE, 8'h00);
		wr(PFD_A_EVENT_CTRL_REG, 8'h01);
		wr(PFD_A_IRQEN, 8'h03);
		sync();
		// Both sources rise together; only A has its action bit set, so B must not capture
		src_a <= 1'b1;
		src_b <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1 chk("irq", 16'h0001, {15'h0, trig_irq});
		rd(PFD_A_IRQFL, d);
		chk("flags", 16'h0001, {8'h00, d});
		rd(PFD_A_CAPA_L, d);
		chk("cap_lo", 16'h0001, {8'h00, d});
		rd(PFD_A_CAPA_H, d);
		chk("cap_hi", 16'h0000, {12'h0, d[3:0]});
		rd(PFD_A_CAPB_L, d);
		chk("cap_b", 16'h0000, {8'h00, d});
		wr(PFD_A_IRQFL, 8'h01);
		wr(PFD_A_CMD, 8'h06);
		src_a <= 1'b0;
		src_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rd(PFD_A_IRQFL, d);
		chk("cleared", 16'h0000, {8'h00, d});
		#1 chk("irq_off", 16'h0000, {15'h0, trig_irq});
		rd(PFD_A_CAPB_L, d);
		chk("soft_b", 16'h0002, {8'h00, d});
	endtask : capture

	task automatic dither();
		logic [1:0] wg [6] = '{WG_ONE, WG_ONE, WG_TWO, WG_FOUR, WG_FOUR, WG_DUAL};
		logic [1:0] ds [6] = '{DSEL_OTB, DSEL_DTB, DSEL_OTAB, DSEL_DTB, DSEL_DTAB, DSEL_OTAB};
		int ex [6] = '{66, 64, 68, 66, 68, 64};
		wr(PFD_A_DITSTEP, 8'h80);
		foreach (ex[i]) begin
			wr(PFD_A_DITHER_CTRL_REG, {6'h00, ds[i]});
			wr(PFD_A_CTRL, {5'h00, wg[i], 1'b1});
			per_chk("dither", 4, ex[i]);
		end
	endtask : dither

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : wrap_up

	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		wrap_up();
	end

	initial begin
		n_fail = 0;
		compares = 0;
		rst_n = 1'b0;
		{wr_en, rd_en, src_a, src_b} = 4'h0;
		addr = 5'h00;
		wdata = 8'h00;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		reset_vals();
		no_effect();
		mode1();
		mode4();
		mode7();
		fault_a(FIM_EXEC_WAIT, 8'h07);
		fault_a(FIM_EXEC_RUN, 8'h02);
		fault_a(FIM_DT_ONLY, 8'h02);
		fault_a(FIM_STOP_WAIT, 8'h06);
		edge_b(FIM_EDGE_JUMP, 8'h01);
		edge_b(FIM_EDGE_BLANK, 8'h00);
		edge_b(FIM_LEVEL_BLANK, 8'h00);
		capture();
		dither();
		wrap_up();
	end
endmodule : test_pfd_timer_core
